// File: include/acs_regs.svh
// register offsets, fields, resets and counts of the conversion sequencer
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH
`define ACS_OFS_CTRL0     8'h00
`define ACS_OFS_CTRL1     8'h04
`define ACS_OFS_RESH      8'h08
`define ACS_OFS_RESL      8'h0c
`define ACS_OFS_IRQ       8'h10
`define ACS_C0_CHAN_LSB   0
`define ACS_C0_FMT_BIT    4
`define ACS_C0_EN_BIT     5
`define ACS_C0_BUSY_BIT   6
`define ACS_C0_START_BIT  7
`define ACS_C1_CLK_LSB    0
`define ACS_C1_REF_LSB    3
`define ACS_C1_SRC_LSB    5
`define ACS_IRQ_GIE_BIT   0
`define ACS_IRQ_CIE_BIT   1
`define ACS_IRQ_REQ_BIT   2
`define ACS_RST_CTRL0     8'h00
`define ACS_RST_CTRL1     8'h00
`define ACS_SAMPLE_TICKS  4'h4
`define ACS_CONV_TICKS    4'hc
`define ACS_TOTAL_TICKS   5'h10
`define ACS_RES_MSB_SEED  12'h800
`define ACS_SRC_EXTERNAL  3'h0
`define ACS_REF_VDD       2'h1
`endif

// File: include/acs_pkg.sv
// types of the conversion sequencer
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE    = 2'b00,
    ACS_SAMPLE  = 2'b01,
    ACS_CONVERT = 2'b10
  } acs_state_t;
endpackage : acs_pkg

// File: src/acs_sequencer.sv
// wishbone controlled successive approximation conversion sequencer
// How it works
// - each result takes 4 sample ticks then 12 convert ticks, 16 total
// - conversion runs by itself; bus stays served throughout
// - start bit low-high-low: high resets converter, fall launches conversion
// - busy flag high during conversion, low once it ends
// - after busy falls result reads as high and low byte registers
// - busy flag readable in control register 0 for polling
// - clock code divides system clock by 1 up to 128 in powers of two
// - enable bit powers converter up; needed before any conversion
// - enable low switches converter off and aborts work
// - source field selects external channel or internal signal
// - external channel field routes chosen channel when source is external
// - two bit field chooses reference source
// - code 01 selects supply reference, other codes external pin
// - format bit sets alignment of result across byte registers
// - interrupt output only when global and converter enables both set
// - completion sets request flag; software clears it
// - result is 12 bits, full scale fff, seeded from msb
//
// The register offsets and the Wishbone register port are this design's own decisions.
`include "acs_regs.svh"
module acs_sequencer
  import acs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        comp_i,
  output logic             power_o,
  output logic             sample_o,
  output logic      [11:0] dac_code_o,
  output logic      [2:0]  source_o,
  output logic      [3:0]  channel_o,
  output logic             channel_en_o,
  output logic             ref_vdd_o,
  output logic             irq_o
);

  // address match for one register
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction : hit

  // place the 12-bit result in the 16-bit byte pair
  function automatic logic [15:0] align(input logic [11:0] r, input logic f);
    align = f ? {4'h0, r} : {r, 4'h0};
  endfunction : align

  logic [3:0]  chan_reg;
  logic        fmt_reg;
  logic        en_reg;
  logic        start_reg;
  logic        start_prev_reg;
  logic [2:0]  clk_sel_reg;
  logic [1:0]  ref_reg;
  logic [2:0]  src_reg;
  logic        gie_reg;
  logic        cie_reg;
  logic        req_reg;
  logic        busy_reg;
  logic [11:0] res_reg;
  logic [11:0] sar_reg;
  logic [11:0] sar_next;
  logic [3:0]  cnt_reg;
  logic [6:0]  div_reg;
  logic [6:0]  div_mask;
  logic        tick;
  logic        wr;
  logic        rd_req;
  logic        start_rise;
  logic        start_fall;
  logic        launch;
  logic        done;
  logic [3:0]  bidx;
  logic [15:0] res_al;
  acs_state_t  state_reg;

  // bus strobes: one ack per request
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr     = rd_req && wb_we_i && wb_sel_i[0];

  // start bit edges
  assign start_rise = start_reg && !start_prev_reg;
  assign start_fall = !start_reg && start_prev_reg;
  assign launch = start_fall && en_reg;

  // mask of 2^code - 1 gives the divide ratio
  assign div_mask = 7'((8'h01 << clk_sel_reg) - 8'h01);
  assign tick     = ((div_reg & div_mask) == div_mask);

  // last convert tick ends the conversion
  assign done = (state_reg == ACS_CONVERT) && tick
             && (cnt_reg == `ACS_CONV_TICKS - 4'h1);
  assign bidx = 4'(4'hb - cnt_reg);
  assign res_al = align(res_reg, fmt_reg);

  // one trial bit per convert tick, msb first
  generate
    for (genvar i = 0; i < 12; i++)
    begin : g_sar
      assign sar_next[i] = (bidx == 4'(i)) ? comp_i
                         : ((bidx != 4'h0) && (bidx - 4'h1 == 4'(i))) ? 1'b1
                         : sar_reg[i];
    end
  endgenerate

  // control register 0
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chan_reg  <= 4'(`ACS_RST_CTRL0);
      fmt_reg   <= 1'b0;
      en_reg    <= 1'b0;
      start_reg <= 1'b0;
    end
    else if (wr && hit(wb_adr_i, `ACS_OFS_CTRL0))
    begin
      chan_reg  <= wb_dat_i[`ACS_C0_CHAN_LSB +: 4];
      fmt_reg   <= wb_dat_i[`ACS_C0_FMT_BIT];
      en_reg    <= wb_dat_i[`ACS_C0_EN_BIT];
      start_reg <= wb_dat_i[`ACS_C0_START_BIT];
    end
  end

  // control register 1
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_sel_reg <= 3'h0;
      ref_reg     <= 2'h0;
      src_reg     <= 3'h0;
    end
    // clock code is software's to set
    else if (wr && hit(wb_adr_i, `ACS_OFS_CTRL1))
    begin
      clk_sel_reg <= wb_dat_i[`ACS_C1_CLK_LSB +: 3];
      ref_reg     <= wb_dat_i[`ACS_C1_REF_LSB +: 2];
      src_reg     <= wb_dat_i[`ACS_C1_SRC_LSB +: 3];
    end
  end

  // interrupt enables and request flag
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gie_reg <= 1'b0;
      cie_reg <= 1'b0;
      req_reg <= 1'b0;
    end
    else
    begin
      if (wr && hit(wb_adr_i, `ACS_OFS_IRQ))
      begin
        gie_reg <= wb_dat_i[`ACS_IRQ_GIE_BIT];
        cie_reg <= wb_dat_i[`ACS_IRQ_CIE_BIT];
        req_reg <= wb_dat_i[`ACS_IRQ_REQ_BIT];
      end
      // completion sets flag, wins over clear
      if (done && en_reg && !start_reg)
        req_reg <= 1'b1;
    end
  end

  // start edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_prev_reg <= 1'b0;
    else
      start_prev_reg <= start_reg;
  end

  // conversion clock divider, realigned at launch
  always_ff @(posedge clk_i)
  begin
    if (rst_i || launch)
      div_reg <= 7'h00;
    else
      div_reg <= 7'(div_reg + 7'h01);
  end

  // sample and convert sequence
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= ACS_IDLE;
      cnt_reg   <= 4'h0;
      sar_reg   <= 12'h000;
      dac_code_o <= 12'h000;
      busy_reg  <= 1'b0;
    end
    else if (!en_reg)
    begin
      state_reg <= ACS_IDLE;
      busy_reg  <= 1'b0;
    end
    else if (start_rise || start_reg)
    begin
      state_reg <= ACS_IDLE;
      busy_reg  <= 1'b0;
    end
    else if (launch)
    begin
      state_reg <= ACS_SAMPLE;
      cnt_reg   <= 4'h0;
      busy_reg  <= 1'b1;
    end
    else if (tick)
    begin
      case (state_reg)
        ACS_SAMPLE:
        begin
          if (cnt_reg == `ACS_SAMPLE_TICKS - 4'h1)
          begin
            state_reg <= ACS_CONVERT;
            cnt_reg   <= 4'h0;
            sar_reg   <= `ACS_RES_MSB_SEED;
            // trial code moves with the register, comparator sees it next tick
            dac_code_o <= `ACS_RES_MSB_SEED;
          end
          else
            cnt_reg <= 4'(cnt_reg + 4'h1);
        end
        ACS_CONVERT:
        begin
          sar_reg <= sar_next;
          dac_code_o <= sar_next;
          cnt_reg <= 4'(cnt_reg + 4'h1);
          if (done)
          begin
            state_reg <= ACS_IDLE;
            busy_reg  <= 1'b0;
          end
        end
        ACS_IDLE:
          cnt_reg <= 4'h0;
        default:
          state_reg <= ACS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      res_reg <= 12'h000;
    else if (done && en_reg && !start_reg)
      res_reg <= sar_next;
  end

  // analog side controls
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      power_o      <= 1'b0;
      sample_o     <= 1'b0;
      source_o     <= 3'h0;
      channel_o    <= 4'h0;
      channel_en_o <= 1'b0;
      ref_vdd_o    <= 1'b0;
    end
    else
    begin
      power_o      <= en_reg;
      sample_o     <= (state_reg == ACS_SAMPLE);
      source_o     <= src_reg;
      // external channel only on external source
      channel_o    <= chan_reg;
      channel_en_o <= en_reg && (src_reg == `ACS_SRC_EXTERNAL);
      // only code 01 selects the supply
      ref_vdd_o    <= (ref_reg == `ACS_REF_VDD);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= req_reg && gie_reg && cie_reg;
  end

  // bus slave answers independent of conversion
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= rd_req;
      wb_dat_o <= 32'h0000_0000;
      if (rd_req)
      begin
        // busy visible in control register 0
        if (hit(wb_adr_i, `ACS_OFS_CTRL0))
          wb_dat_o <= {24'h0, start_reg, busy_reg, en_reg, fmt_reg, chan_reg};
        else if (hit(wb_adr_i, `ACS_OFS_CTRL1))
          wb_dat_o <= {24'h0, src_reg, ref_reg, clk_sel_reg};
        else if (hit(wb_adr_i, `ACS_OFS_RESH))
          wb_dat_o <= {24'h0, res_al[15:8]};
        else if (hit(wb_adr_i, `ACS_OFS_RESL))
          wb_dat_o <= {24'h0, res_al[7:0]};
        else if (hit(wb_adr_i, `ACS_OFS_IRQ))
          wb_dat_o <= {29'h0, req_reg, cie_reg, gie_reg};
      end
    end
  end

  // helper: ticks seen since launch
  logic [4:0] tick_cnt;
  logic       irq_cond;
  assign irq_cond = req_reg && gie_reg && cie_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || launch)
      tick_cnt <= 5'h00;
    else if (busy_reg && tick)
      tick_cnt <= 5'(tick_cnt + 5'h01);
  end

  // checks on sequence, divider, power and interrupt
  a_total_ticks: assert property (@(posedge clk_i) disable iff (rst_i)
    done && en_reg && !start_reg |-> tick_cnt == `ACS_TOTAL_TICKS - 5'h01)
    else $error("conversion did not take 16 ticks");

  a_sample_span: assert property (@(posedge clk_i) disable iff (rst_i)
    state_reg == ACS_SAMPLE && tick && cnt_reg == 4'h3 && en_reg
    && !start_reg |=> state_reg == ACS_CONVERT)
    else $error("sampling did not end after four ticks");

  a_busy_launch: assert property (@(posedge clk_i) disable iff (rst_i)
    launch |=> busy_reg && state_reg == ACS_SAMPLE)
    else $error("busy not raised at launch");

  a_rise_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    start_rise |=> !busy_reg ##1 !busy_reg)
    else $error("start high did not reset converter");

  a_off_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    start_fall && !en_reg |=> !busy_reg)
    else $error("start while disabled began a conversion");

  a_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_reg |=> !busy_reg && !power_o)
    else $error("converter stayed active while disabled");

  a_div_full: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_sel_reg == 3'h7 && tick |-> div_reg == 7'h7f)
    else $error("divide by 128 ticked early");

  a_div_unity: assert property (@(posedge clk_i) disable iff (rst_i)
    clk_sel_reg == 3'h0 |-> tick)
    else $error("divide by 1 missed a tick");

  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 irq_o == $past(irq_cond))
    else $error("interrupt not gated by both enables");

  a_done_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    done && en_reg && !start_reg |=> req_reg)
    else $error("completion did not set request");

  a_ref_code: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 ref_vdd_o == ($past(ref_reg) == 2'h1))
    else $error("reference select decoded wrongly");

  c_launch: cover property (@(posedge clk_i) disable iff (rst_i) launch);
  c_done: cover property (@(posedge clk_i) disable iff (rst_i) done ##1 !busy_reg);
  c_abort: cover property (@(posedge clk_i) disable iff (rst_i) busy_reg && start_rise);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));

endmodule : acs_sequencer

// File: test/acs_sequencer_test.sv
// self-checking bench of the conversion sequencer over wishbone
`include "acs_regs.svh"
module acs_sequencer_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        comp_i;
  logic        power_o;
  logic        sample_o;
  logic [11:0] dac_code_o;
  logic [2:0]  source_o;
  logic [3:0]  channel_o;
  logic        channel_en_o;
  logic        ref_vdd_o;
  logic        irq_o;
  logic [11:0] target = 12'h000;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          samp_cnt = 0;

  acs_sequencer i_acs_sequencer (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comp_i(comp_i), .power_o(power_o),
    .sample_o(sample_o), .dac_code_o(dac_code_o), .source_o(source_o),
    .channel_o(channel_o), .channel_en_o(channel_en_o), .ref_vdd_o(ref_vdd_o),
    .irq_o(irq_o)
  );

  // ideal comparator against the analog input level in target
  assign comp_i = (target >= dac_code_o);

  // system clock, 5 ns period
  always #2.5 clk_i = ~clk_i;

  // cycle count, sample phase length and hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (sample_o === 1'b1) samp_cnt++;
    if (cyc == 20000)
    begin
      fails++;
      $display("MISMATCH timeout expected completion seen hang");
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // one classic wishbone cycle, entered right after a rising edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                         output logic [31:0] rd);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    check("ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] d;
    wb_xfer(1'b1, adr, wd, d);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb_xfer(1'b0, adr, 8'h00, d);
    check(name, exp, d);
  endtask : rd_chk

  // one conversion at clock code c, polled to completion
  task automatic convert(input logic [2:0] c, input logic fmt, input logic gie);
    logic [31:0] d;
    logic [7:0]  base;
    int          t0;
    int          n;
    int          span;
    base = 8'h20 | ({7'h0, fmt} << `ACS_C0_FMT_BIT);
    span = 16 << c;
    wr(`ACS_OFS_CTRL1, {3'h0, 2'h1, c});
    wr(`ACS_OFS_IRQ, {6'h0, 1'b1, gie});
    wr(`ACS_OFS_CTRL0, base);
    repeat (8) @(posedge clk_i);
    samp_cnt = 0;
    wr(`ACS_OFS_CTRL0, base | 8'h80);
    wr(`ACS_OFS_CTRL0, base);
    t0 = cyc;
    rd_chk("busy_set", `ACS_OFS_CTRL0, {24'h0, base | 8'h40});
    n = 0;
    do
    begin
      wb_xfer(1'b0, `ACS_OFS_CTRL0, 8'h00, d);
      n++;
    end
    while (d[`ACS_C0_BUSY_BIT] === 1'b1 && n < 1000);
    check("busy_clear", 32'h0, {31'h0, d[`ACS_C0_BUSY_BIT]});
    check("conv_span_lo", 32'h1, {31'h0, (cyc - t0) >= span - 4});
    check("conv_span_hi", 32'h1, {31'h0, (cyc - t0) <= span + 4});
    check("sample_len", 4 << c, samp_cnt);
    if (fmt)
    begin
      rd_chk("res_high", `ACS_OFS_RESH, {28'h0, target[11:8]});
      rd_chk("res_low", `ACS_OFS_RESL, {24'h0, target[7:0]});
    end
    else
    begin
      rd_chk("res_high", `ACS_OFS_RESH, {24'h0, target[11:4]});
      rd_chk("res_low", `ACS_OFS_RESL, {24'h0, target[3:0], 4'h0});
    end
    check("irq_out", {31'h0, gie}, {31'h0, irq_o});
    rd_chk("irq_req", `ACS_OFS_IRQ, {29'h0, 3'b110 | {2'b0, gie}});
    wr(`ACS_OFS_IRQ, {6'h0, 1'b1, gie});
    check("irq_clear", 32'h0, {31'h0, irq_o});
    $display("test conversion code %0d done", c);
  endtask : convert

  logic [11:0] tgt [8] = '{12'hfff, 12'h000, 12'h5a3, 12'h801,
                           12'h7ff, 12'h001, 12'hc3c, 12'h800};

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("ctrl0_rst", `ACS_OFS_CTRL0, 32'h0);
    rd_chk("ctrl1_rst", `ACS_OFS_CTRL1, 32'h0);
    wr(8'h20, 8'h5a);
    rd_chk("unmapped", 8'h20, 32'h0);
    check("power_rst", 32'h0, {31'h0, power_o});
    $display("test reset done");
    wr(`ACS_OFS_CTRL0, 8'h80);
    wr(`ACS_OFS_CTRL0, 8'h00);
    rd_chk("start_off", `ACS_OFS_CTRL0, 32'h0);
    rd_chk("req_off", `ACS_OFS_IRQ, 32'h0);
    $display("test start disabled done");
    wr(`ACS_OFS_CTRL0, 8'h25);
    for (int r = 0; r < 4; r++)
    begin
      wr(`ACS_OFS_CTRL1, 8'(r << `ACS_C1_REF_LSB));
      check("ref_vdd", {31'h0, r == 1}, {31'h0, ref_vdd_o});
    end
    check("power_on", 32'h1, {31'h0, power_o});
    check("chan", 32'h5, {28'h0, channel_o});
    check("chan_en", 32'h1, {31'h0, channel_en_o});
    wr(`ACS_OFS_CTRL0, 8'h2c);
    wr(`ACS_OFS_CTRL1, 8'h60);
    check("source", 32'h3, {29'h0, source_o});
    check("chan_off", 32'h0, {31'h0, channel_en_o});
    $display("test routing done");
    for (int c = 0; c < 8; c++)
    begin
      target = tgt[c];
      convert(3'(c), c[0], c != 7);
    end
    wr(`ACS_OFS_CTRL0, 8'h20);
    wr(`ACS_OFS_CTRL0, 8'ha0);
    wr(`ACS_OFS_CTRL0, 8'h20);
    wr(`ACS_OFS_CTRL0, 8'ha0);
    rd_chk("abort", `ACS_OFS_CTRL0, 32'ha0);
    wr(`ACS_OFS_CTRL0, 8'h00);
    check("power_off", 32'h0, {31'h0, power_o});
    $display("test abort done");
    test_done();
  end
endmodule : acs_sequencer_test
